/* design/ccsi_top.sv */
// status indicator top: register port, led control and transceiver mode pins
`timescale 1ns/1ps
`include "ccsi_regs.svh"
module ccsi_top #(
    parameter int NCH      = 2,
    parameter int B1_TICKS = `CCSI_BLINK1_US,
    parameter int B2_TICKS = `CCSI_BLINK2_US,
    parameter int B3_TICKS = `CCSI_BLINK3_US,
    parameter int TR_TICKS = `CCSI_TRAFFIC_US
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rstn,
    // register port
    input  wire logic [7:0]     addr,
    input  wire logic [31:0]    wdata,
    input  wire logic           wr,
    input  wire logic           rd,
    output logic      [31:0]    rdata,
    // per-channel events from the can controller
    input  wire logic [NCH-1:0] chan_init,
    input  wire logic [NCH-1:0] bus_error,
    input  wire logic [NCH-1:0] frame_act,
    // leds
    output logic                power_led,
    output logic      [NCH-1:0] status_led,
    output logic      [NCH-1:0] traffic_led,
    // transceiver pins
    output logic                xcvr_enable,
    output logic                transceiver_sleep_n,
    output logic                bus_termination_on,
    input  wire logic           xcvr_fault_n,
    // interrupt
    output logic                irq
);
    // -------------------------------------------------------------
    // reset release and synchronisers
    // -------------------------------------------------------------
    logic       rs1_q;
    logic       rst_n;
    logic       fault_s1_q;
    logic       fault_q;
    logic       fault_prev_q;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rs1_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rst_n <= rs1_q;
        end
    end

    // fault line idles high, so the synchroniser resets to that level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fault_s1_q   <= 1'b1;
            fault_q      <= 1'b1;
            fault_prev_q <= 1'b1;
        end else begin
            fault_s1_q   <= xcvr_fault_n;
            fault_q      <= fault_s1_q;
            fault_prev_q <= fault_q;
        end
    end

    // -------------------------------------------------------------
    // microsecond tick
    // -------------------------------------------------------------
    localparam int TICK_DIV = `CCSI_TICK_DIV;
    logic [5:0] div_q;
    logic       tick_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q  <= '0;
            tick_q <= 1'b0;
        end else begin
            tick_q <= (div_q == 6'(TICK_DIV - 1));
            div_q  <= (div_q == 6'(TICK_DIV - 1)) ? '0 : div_q + 6'h1;
        end
    end

    // -------------------------------------------------------------
    // registers
    // -------------------------------------------------------------
    logic [2:0]        ctrl_q;
    ccsi_pkg::ccsi_xcvr_t xcvr_q;
    logic [1:0]        irq_stat_q;
    logic [1:0]        irq_mask_q;
    logic [NCH-1:0]    err_prev_q;

    // register layout is enable at bit 0, the struct has it at the top
    localparam logic [2:0] XCVR_RST = `CCSI_XCVR_RESET;

    wire sel_ctrl  = (addr == `CCSI_ADDR_CTRL);
    wire sel_xcvr  = (addr == `CCSI_ADDR_XCVR);
    wire sel_stat  = (addr == `CCSI_ADDR_STAT);
    wire sel_istat = (addr == `CCSI_ADDR_IRQ_STAT);
    wire sel_imask = (addr == `CCSI_ADDR_IRQ_MASK);

    // fault edge and new bus errors are the interrupt events
    wire       ev_fault = fault_prev_q & ~fault_q;
    wire       ev_berr  = |(bus_error & ~err_prev_q);
    wire [1:0] ev_vec   = {ev_berr, ev_fault};
    wire       clr_stat = rd & sel_istat;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= 3'h0;
        end else if (wr && sel_ctrl) begin
            ctrl_q <= wdata[2:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            xcvr_q <= ccsi_pkg::ccsi_xcvr_t'({XCVR_RST[`CCSI_XCVR_ENABLE],
                                              XCVR_RST[`CCSI_XCVR_SLEEP_N],
                                              XCVR_RST[`CCSI_XCVR_TERM]});
        end else if (wr && sel_xcvr) begin
            xcvr_q <= ccsi_pkg::ccsi_xcvr_t'({wdata[`CCSI_XCVR_ENABLE],
                                              wdata[`CCSI_XCVR_SLEEP_N],
                                              wdata[`CCSI_XCVR_TERM]});
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_mask_q <= 2'h0;
        end else if (wr && sel_imask) begin
            irq_mask_q <= wdata[1:0];
        end
    end

    // a new event in the clearing read cycle survives
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat_q <= 2'h0;
            err_prev_q <= '0;
        end else begin
            irq_stat_q <= (clr_stat ? 2'h0 : irq_stat_q) | ev_vec;
            err_prev_q <= bus_error;
        end
    end

    // -------------------------------------------------------------
    // read port
    // -------------------------------------------------------------
    logic [31:0] rmux;
    wire  [31:0] ctrl_rd = {29'h0, ctrl_q};
    wire  [31:0] xcvr_rd = {28'h0, fault_q, xcvr_q.termination_on,
                            xcvr_q.sleep_n, xcvr_q.enable};
    wire  [31:0] stat_rd = {16'h0, 8'(traffic_led), 8'(status_led)};
    wire  [31:0] istat_rd = {30'h0, irq_stat_q};
    wire  [31:0] imask_rd = {30'h0, irq_mask_q};

    assign rmux = sel_ctrl  ? ctrl_rd :
                  sel_xcvr  ? xcvr_rd :
                  sel_stat  ? stat_rd :
                  sel_istat ? istat_rd :
                  sel_imask ? imask_rd : 32'h0;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 32'h0;
        end else begin
            rdata <= rd ? rmux : 32'h0;
        end
    end

    // -------------------------------------------------------------
    // outputs
    // -------------------------------------------------------------
    // fault level goes nowhere but the register and interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            power_led           <= 1'b0;
            xcvr_enable         <= 1'b1;
            transceiver_sleep_n <= 1'b1;
            bus_termination_on  <= 1'b0;
            irq                 <= 1'b0;
        end else begin
            power_led           <= 1'b1;
            xcvr_enable         <= xcvr_q.enable;
            transceiver_sleep_n <= xcvr_q.sleep_n;
            bus_termination_on  <= xcvr_q.termination_on;
            irq                 <= |(irq_stat_q & irq_mask_q);
        end
    end

    // -------------------------------------------------------------
    // channels
    // -------------------------------------------------------------
    for (genvar i = 0; i < NCH; i++) begin : g_ch
        ccsi_channel #(
            .B1_TICKS (B1_TICKS),
            .B2_TICKS (B2_TICKS),
            .B3_TICKS (B3_TICKS),
            .TR_TICKS (TR_TICKS)
        ) u_ch (
            .clk         (clk),
            .rst_n       (rst_n),
            .tick        (tick_q),
            .logged_in   (ctrl_q[`CCSI_CTRL_LOGGED_IN]),
            .usb_link    (ctrl_q[`CCSI_CTRL_USB_LINK]),
            .fw_update   (ctrl_q[`CCSI_CTRL_FW_UPD]),
            .chan_init   (chan_init[i]),
            .bus_error   (bus_error[i]),
            .frame_act   (frame_act[i]),
            .status_led  (status_led[i]),
            .traffic_led (traffic_led[i]),
            .state       ()
        );
    end
endmodule : ccsi_top

/* design/ccsi_regs.svh */
// register offsets, field positions, reset values and timing figures of the status indicator
`ifndef CCSI_REGS_SVH
`define CCSI_REGS_SVH

`define CCSI_ADDR_CTRL      8'h00
`define CCSI_ADDR_XCVR      8'h04
`define CCSI_ADDR_STAT      8'h08
`define CCSI_ADDR_IRQ_STAT  8'h0C
`define CCSI_ADDR_IRQ_MASK  8'h10

// ctrl fields
`define CCSI_CTRL_LOGGED_IN 0
`define CCSI_CTRL_USB_LINK  1
`define CCSI_CTRL_FW_UPD    2

// transceiver control fields
`define CCSI_XCVR_ENABLE    0
`define CCSI_XCVR_SLEEP_N   1
`define CCSI_XCVR_TERM      2
`define CCSI_XCVR_RESET     3'h3

// irq status fields
`define CCSI_IRQ_FAULT      0
`define CCSI_IRQ_BUS_ERR    1

// blink half periods in microseconds, clock rate in MHz and microsecond tick divider
`define CCSI_BLINK1_US      250000
`define CCSI_BLINK2_US      100000
`define CCSI_BLINK3_US      50000
`define CCSI_TRAFFIC_US     20000
`define CCSI_CLK_MHZ        40
`define CCSI_TICK_DIV       40

`endif

/* design/ccsi_pkg.sv */
// types shared by the status indicator files
package ccsi_pkg;
    typedef enum logic [2:0] {
        CCSI_ST_OFF     = 3'b000,
        CCSI_ST_LOGIN   = 3'b001,
        CCSI_ST_READY   = 3'b010,
        CCSI_ST_RUN     = 3'b011,
        CCSI_ST_BUS_ERR = 3'b100,
        CCSI_ST_FW_UPD  = 3'b101
    } ccsi_state_t;

    typedef struct packed {
        logic enable;
        logic sleep_n;
        logic termination_on;
    } ccsi_xcvr_t;
endpackage : ccsi_pkg

/* design/ccsi_channel.sv */
// one channel's status and traffic led logic
`timescale 1ns/1ps
`include "ccsi_regs.svh"
module ccsi_channel #(
    parameter int B1_TICKS = `CCSI_BLINK1_US,
    parameter int B2_TICKS = `CCSI_BLINK2_US,
    parameter int B3_TICKS = `CCSI_BLINK3_US,
    parameter int TR_TICKS = `CCSI_TRAFFIC_US
) (
    // clock, reset and microsecond tick
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic tick,
    // global state
    input  wire logic logged_in,
    input  wire logic usb_link,
    input  wire logic fw_update,
    // channel state
    input  wire logic chan_init,
    input  wire logic bus_error,
    input  wire logic frame_act,
    // leds and decoded channel state
    output logic      status_led,
    output logic      traffic_led,
    output ccsi_pkg::ccsi_state_t state
);
    localparam int CW = 20;
    logic [CW-1:0] cnt_q;
    logic [CW-1:0] half;
    logic          blink_q;
    logic [CW-1:0] tr_cnt_q;
    logic          tr_q;
    logic          tr_busy;
    logic          st_d;

    // fixed precedence: update beats login beats error beats init
    assign state = fw_update          ? ccsi_pkg::CCSI_ST_FW_UPD :
                   (!usb_link || !logged_in) ? ccsi_pkg::CCSI_ST_LOGIN :
                   bus_error          ? ccsi_pkg::CCSI_ST_BUS_ERR :
                   chan_init          ? ccsi_pkg::CCSI_ST_RUN :
                                        ccsi_pkg::CCSI_ST_READY;

    // distinct half periods per pattern
    assign half = (state == ccsi_pkg::CCSI_ST_FW_UPD)  ? CW'(B3_TICKS) :
                  (state == ccsi_pkg::CCSI_ST_BUS_ERR) ? CW'(B2_TICKS) :
                                                          CW'(B1_TICKS);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q   <= '0;
            blink_q <= 1'b0;
        end else if (tick) begin
            if (cnt_q >= half - CW'(1)) begin
                cnt_q   <= '0;
                blink_q <= ~blink_q;
            end else begin
                cnt_q <= cnt_q + CW'(1);
            end
        end
    end

    always_comb begin
        case (state)
            ccsi_pkg::CCSI_ST_LOGIN:   st_d = blink_q;
            ccsi_pkg::CCSI_ST_BUS_ERR: st_d = blink_q;
            ccsi_pkg::CCSI_ST_FW_UPD:  st_d = blink_q;
            ccsi_pkg::CCSI_ST_READY:   st_d = 1'b1;
            ccsi_pkg::CCSI_ST_RUN:     st_d = 1'b0;
            default:                   st_d = 1'b0;
        endcase
    end

    // traffic blink runs one half period per frame burst, only once initialised
    assign tr_busy = (tr_cnt_q != '0);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tr_cnt_q <= '0;
            tr_q     <= 1'b0;
        end else if (!chan_init) begin
            tr_cnt_q <= '0;
            tr_q     <= 1'b0;
        end else if (tick) begin
            if (tr_busy) begin
                tr_cnt_q <= tr_cnt_q - CW'(1);
            end else if (frame_act) begin
                // the toggle tick counts as the first of the hold
                tr_cnt_q <= CW'(TR_TICKS - 1);
                tr_q     <= ~tr_q;
            end else begin
                tr_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_led  <= 1'b0;
            traffic_led <= 1'b0;
        end else begin
            status_led  <= st_d;
            traffic_led <= tr_q;
        end
    end
endmodule : ccsi_channel

/* sim/ccsi_top_properties.sv */
// concurrent checks on the status indicator top ports
`timescale 1ns/1ps
module ccsi_top_properties #(
    parameter int NCH = 2
) (
    input wire logic           clk,
    input wire logic           rstn,
    input wire logic [7:0]     addr,
    input wire logic [31:0]    wdata,
    input wire logic           wr,
    input wire logic           rd,
    input wire logic [31:0]    rdata,
    input wire logic [NCH-1:0] chan_init,
    input wire logic [NCH-1:0] bus_error,
    input wire logic           power_led,
    input wire logic [NCH-1:0] status_led,
    input wire logic [NCH-1:0] traffic_led,
    input wire logic           xcvr_enable,
    input wire logic           transceiver_sleep_n,
    input wire logic           bus_termination_on,
    input wire logic           xcvr_fault_n,
    input wire logic           irq
);
    // --------
    // shadow of ctrl and mask, since neither shows at the pins
    // --------
    logic [2:0] ctrl_q;
    logic [1:0] mask_q;
    wire        host_ok = ctrl_q == 3'h3;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= 3'h0;
            mask_q <= 2'h0;
        end else if (wr) begin
            if (addr == 8'h00) ctrl_q <= wdata[2:0];
            if (addr == 8'h10) mask_q <= wdata[1:0];
        end
    end

    // pins are only settled from the second edge of a reset
    logic rst_seen_q;

    always_ff @(posedge clk) begin
        rst_seen_q <= !rstn;
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    a_power_lit: assert property (rstn [*6] |-> power_led)
        else $error("power led dark after reset");
    a_reset_pins: assert property (disable iff (1'b0) !rstn && rst_seen_q |->
        xcvr_enable && transceiver_sleep_n && !bus_termination_on)
        else $error("transceiver pins wrong in reset");
    a_rdata_idle: assert property (!rd |=> rdata == 32'h0)
        else $error("read data not idle");
    a_xcvr_write: assert property ($past(wr, 2) && $past(addr, 2) == 8'h04 |->
        {bus_termination_on, transceiver_sleep_n, xcvr_enable} == $past(wdata[2:0], 2))
        else $error("mode pins do not follow write");
    a_irq_masked: assert property ((mask_q == 2'h0) [*3] |-> !irq)
        else $error("irq raised while masked");
    a_fault_irq: assert property (mask_q[0] && $fell(xcvr_fault_n) |-> ##[1:8] irq)
        else $error("fault edge gave no irq");
    a_traffic_gate: assert property ((!chan_init[0]) [*3] |-> !traffic_led[0])
        else $error("traffic led lit before init");
    a_init_dark: assert property ((host_ok && chan_init[0] && !bus_error[0]) [*4] |->
        !status_led[0] && power_led)
        else $error("status led lit after init");
    a_steady_on: assert property ((host_ok && !chan_init[0] && !bus_error[0]) [*4] |->
        status_led[0])
        else $error("status led not steady");
endmodule : ccsi_top_properties

bind ccsi_top ccsi_top_properties #(.NCH(NCH)) ccsi_top_properties_i (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .chan_init(chan_init), .bus_error(bus_error),
    .power_led(power_led), .status_led(status_led), .traffic_led(traffic_led),
    .xcvr_enable(xcvr_enable), .transceiver_sleep_n(transceiver_sleep_n),
    .bus_termination_on(bus_termination_on), .xcvr_fault_n(xcvr_fault_n), .irq(irq));

/* sim/ccsi_xcvr_model.sv */
// behavioural transceiver seen at the mode pins
`timescale 1ns/1ps
module ccsi_xcvr_model (
    // clock
    input wire logic clk,
    // mode pins
    input wire logic enable,
    input wire logic sleep_n,
    input wire logic termination_on,
    // fault injection from the bench
    input wire logic fault_req,
    // status
    output logic     fault_n
);
    // --------
    // a sleeping part cannot report, so the pulled-up line reads high
    // --------
    initial fault_n = 1'b1;
    always @(posedge clk) fault_n <= !(fault_req && enable && sleep_n);
endmodule : ccsi_xcvr_model

/* sim/tb_top.sv */
// self-checking bench for the status indicator top
`timescale 1ns/1ps
module tb_top;
    logic        clk, rstn, wr, rd, rd_q, fault_req, power_led, irq;
    logic        xcvr_enable, transceiver_sleep_n, bus_termination_on, xcvr_fault_n;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [1:0]  chan_init, bus_error, frame_act, status_led, traffic_led;
    logic [31:0] exp_q[$];
    int          fails, total_checks, cycles, seed, n;
    wire  [2:0]  pins = {bus_termination_on, transceiver_sleep_n, xcvr_enable};
    wire  [3:0]  leds = {traffic_led, status_led};

    // short blink counts keep the run brief
    ccsi_top #(.NCH(2), .B1_TICKS(8), .B2_TICKS(4), .B3_TICKS(2), .TR_TICKS(2)) ccsi_top_i (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .chan_init(chan_init), .bus_error(bus_error),
        .frame_act(frame_act), .power_led(power_led), .status_led(status_led),
        .traffic_led(traffic_led), .xcvr_enable(xcvr_enable),
        .transceiver_sleep_n(transceiver_sleep_n), .bus_termination_on(bus_termination_on),
        .xcvr_fault_n(xcvr_fault_n), .irq(irq));
    ccsi_xcvr_model ccsi_xcvr_model_i (.clk(clk), .enable(xcvr_enable),
        .sleep_n(transceiver_sleep_n), .termination_on(bus_termination_on),
        .fault_req(fault_req), .fault_n(xcvr_fault_n));

    // --------
    // clock, tasks and result monitor
    // --------
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic cyc(input int k);
        repeat (k) @(posedge clk);
    endtask : cyc

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wr32

    task automatic rd32(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask : rd32

    // edges between two toggles of one led, expected ticks times 40 clocks
    task automatic meas(input int i, input int ticks);
        logic s;
        int   c;
        for (int k = 0; k < 2; k++) begin
            s = leds[i];
            c = 0;
            while (leds[i] === s && c < 2000) begin
                @(posedge clk);
                c++;
            end
        end
        chk(32'(c), 32'(ticks * 40));
    endtask : meas

    always @(posedge clk) begin
        if (rd_q) chk(rdata, exp_q.pop_front());
        rd_q <= rd;
        cycles++;
        if (cycles == 60000) begin
            fails++;
            finish_test();
        end
    end

    // --------
    // main sequence
    // --------
    initial begin
        {rstn, wr, rd, rd_q, fault_req, addr, wdata} = '0;
        {chan_init, bus_error, frame_act} = '0;
        {fails, total_checks, cycles} = '0;
        seed = 86393;
        cyc(12);
        chk({pins, power_led}, 32'h6);
        rstn <= 1'b1;
        cyc(5);
        rd32(8'h04, 32'hB);
        rd32(8'h20, 32'h0);
        wr32(8'h20, 32'hFFFFFFFF);
        rd32(8'h00, 32'h0);
        for (n = 0; n < 3; n++) begin
            wr32(8'h00, 32'(n));
            meas(0, 8);
        end
        wr32(8'h00, 32'h3);
        cyc(4);
        chk(status_led, 32'h3);
        rd32(8'h08, 32'h3);
        chan_init <= 2'h3;
        cyc(4);
        chk({power_led, status_led}, 32'h4);
        frame_act <= 2'h3;
        meas(2, 2);
        chan_init <= 2'h0;
        cyc(3);
        chk(traffic_led, 32'h0);
        chan_init <= 2'h3;
        frame_act <= 2'h0;
        wr32(8'h10, 32'h2);
        bus_error <= 2'h1;
        cyc(8);
        chk(irq, 32'h1);
        meas(0, 4);
        chk(status_led[1], 32'h0);
        rd32(8'h0C, 32'h2);
        cyc(3);
        chk(irq, 32'h0);
        rd32(8'h0C, 32'h0);
        bus_error <= 2'h0;
        wr32(8'h10, 32'h1);
        fault_req <= 1'b1;
        cyc(8);
        chk({irq, pins}, 32'hB);
        rd32(8'h04, 32'h3);
        rd32(8'h0C, 32'h1);
        fault_req <= 1'b0;
        wr32(8'h00, 32'h7);
        // let the jump from the dark state show before timing starts
        cyc(2);
        meas(0, 2);
        repeat (6) begin
            v = $random(seed) & 32'h7;
            wr32(8'h04, v);
            cyc(1);
            chk(pins, v);
            rd32(8'h04, v | 32'h8);
        end
        cyc(3);
        finish_test();
    end
endmodule : tb_top
